/* tcrc_pkg.sv */
// Package for the timer 2 capture/reload counter block.
// Assumes one 125 MHz system clock; registers sit on AHB-Lite.
package tcrc_pkg;

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_CTL = 8'hC8; // timer2_control
    localparam logic [7:0] IDX_MODE = 8'hC9; // timer2_mode
    localparam logic [7:0] IDX_RLL = 8'hCA; // timer2_reload_low
    localparam logic [7:0] IDX_RLH = 8'hCB; // timer2_reload_high
    localparam logic [7:0] IDX_CNL = 8'hCC; // timer2_count_low
    localparam logic [7:0] IDX_CNH = 8'hCD; // timer2_count_high
    localparam logic [7:0] IDX_AUX = 8'hCE; // speed and irq enable

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int B_TF = 7; // overflow_flag
    localparam int B_EXF = 6; // external_flag
    localparam int B_RXB = 5; // rx baud source select
    localparam int B_TXB = 4; // tx_baud_source_select
    localparam int B_EXEN = 3; // external_enable
    localparam int B_RUN = 2; // run_control
    localparam int B_CT = 1; // counter_timer_select
    localparam int B_CPRL = 0; // capture_reload_select
    localparam int B_OE = 1; // clock_output_enable
    localparam int B_DOWN_COUNT_ENABLE = 0; // down_count_enable
    localparam int B_IEN = 1; // timer_interrupt_enable
    localparam int B_SPD = 0; // speed_select

    // ------------------------------------------------------------
    // Reset values and cycle counts
    // ------------------------------------------------------------
    localparam logic [7:0] CTL_RST = 8'h00;
    localparam logic [15:0] CNT_RST = 16'h0000;
    localparam logic [15:0] CNT_ALL1 = 16'hFFFF;
    localparam logic [3:0] DIV_BAUD = 4'h2; // clocks per tick
    localparam logic [3:0] DIV_SLOW = 4'hC; // timer, speed 0
    localparam logic [3:0] DIV_FAST = 4'h4; // timer, speed 1

    // Whole state of the block
    typedef struct packed {
        logic [7:0] ctl;
        logic [1:0] mode;
        logic [1:0] aux;
        logic [15:0] cnt;
        logic [15:0] rcap;
        logic [3:0] pre;
        logic [2:0] t2s;
        logic t2l;
        logic [2:0] exs;
        logic exl;
        logic wv;
        logic [7:0] widx;
        logic [31:0] rdata;
        logic irq;
        logic rxt;
        logic txt;
        logic cko;
        logic ckoe;
        logic rdy;
    } tcrc_state_s;

endpackage

/* tcrc_top.sv */
// Timer 2: 16-bit timer/counter with capture/reload, up/down,
// baud-rate generator and clock output, behind an AHB-Lite slave.
// Assumes pins are asynchronous and the other timer's overflow
// pulse and the serial mode come from logic on hclk.
//
// Summary of operation
// R1 - Overflow flag sets on FFFF to 0000 roll
// R2 - Down count sets flag when count equals reload
// R3 - Overflow flag sets only with both baud sources 0
// R4 - Software alone clears the overflow flag
// R5 - Trigger falling edge sets external flag when enabled
// R6 - Down mode: external flag toggles, no interrupt
// R7 - External flag set requests interrupt if enabled
// R8 - Rx baud source selects other or own overflow
// R9 - Tx baud source selects other or own overflow
// R10 - Any baud source forces baud generator, clock/2
// R11 - Baud or clock-out mode ticks every two clocks
// R12 - Baud mode ignores capture select, always reloads
// R13 - Trigger needs enable; in baud mode it sets the external flag only, no load
// R14 - Run control low halts and holds the count
// R15 - Select chooses prescaled clock or count pin edges
// R16 - Reload mode loads reload on overflow or trigger
// R17 - Capture mode copies count to reload on trigger
// R18 - Clock output drives count pin, no rollover irq
// R19 - Down enable with trigger level sets direction
// R20 - Reserved mode bits read with no meaning
// R21 - Interrupt passes only when its enable is set
// R22 - Up when trigger high, down when low, underflow FFFF
// R23 - Interrupt is OR of overflow and external flags
`timescale 1ns/10ps
module tcrc_top
    import tcrc_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic count_input_pin_i,
    output logic count_input_pin_o,
    output logic count_input_pin_oe,
    input wire logic trigger_pin,
    input wire logic other_timer_ovf,
    input wire logic [1:0] serial_mode,
    output logic rx_baud_tick,
    output logic tx_baud_tick,
    output logic timer_irq
);

    // ------------------------------------------------------------
    // State and helper signals
    // ------------------------------------------------------------
    tcrc_state_s q; // Registered state
    tcrc_state_s d; // Next state
    logic baud; // Baud generator mode
    logic clkout; // Clock output mode
    logic dmode; // Reload mode with down count
    logic up; // Count direction
    logic tick; // Count advance this cycle
    logic ovf; // Overflow or underflow
    logic t2_edge; // Count pin falling edge
    logic ex_edge; // Trigger pin falling edge
    logic trig; // Accepted trigger event
    logic wr_ctl; // Bus write to control
    logic wr_cnt; // Bus write to either count byte

    // Register read decode
    function automatic logic [31:0] reg_read(
        input logic [7:0] idx,
        input tcrc_state_s s
    );
        logic [31:0] r;
        r = 32'h0000_0000;
        case (idx)
            IDX_CTL: r[7:0] = s.ctl;
            IDX_MODE: r[1:0] = s.mode; // Reserved bits give 0 R20
            IDX_RLL: r[7:0] = s.rcap[7:0];
            IDX_RLH: r[7:0] = s.rcap[15:8];
            IDX_CNL: r[7:0] = s.cnt[7:0];
            IDX_CNH: r[7:0] = s.cnt[15:8];
            IDX_AUX: r[1:0] = s.aux;
            default: r = 32'h0000_0000;
        endcase
        return r;
    endfunction

    // ------------------------------------------------------------
    // Mode decode and events
    // ------------------------------------------------------------

    // Either baud source forces baud mode
    assign baud = q.ctl[B_RXB] | q.ctl[B_TXB]; // R10
    // Clock output needs the timer function
    assign clkout = q.mode[B_OE] & ~q.ctl[B_CT]; // R18
    // Down count only in plain reload mode
    assign dmode = q.mode[B_DOWN_COUNT_ENABLE] & ~q.ctl[B_CPRL] & ~baud; // R19
    // Trigger level high counts up, low counts down
    assign up = ~(dmode & ~q.exl); // R22
    // Agreed-level falling edges on the pins
    assign t2_edge = q.t2l & (q.t2s[1] == q.t2s[2]) & ~q.t2s[1];
    assign ex_edge = q.exl & (q.exs[1] == q.exs[2]) & ~q.exs[1];
    // Trigger used only when enabled, not as direction
    assign trig = ex_edge & q.ctl[B_EXEN] & ~dmode; // R5 R13
    assign wr_ctl = q.wv & (q.widx == IDX_CTL);
    assign wr_cnt = q.wv & ((q.widx == IDX_CNL) |
                            (q.widx == IDX_CNH));

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------

    // Whole block: bus, pins, prescaler, counter, flags
    always_comb
    begin
        d = q;
        tick = 1'b0;
        ovf = 1'b0;
        // Pin synchronisers, three stages
        d.t2s = {q.t2s[1:0], count_input_pin_i};
        d.exs = {q.exs[1:0], trigger_pin};
        // Level follows once stages two and three agree
        if (q.t2s[1] == q.t2s[2])
        begin
            d.t2l = q.t2s[1];
        end
        if (q.exs[1] == q.exs[2])
        begin
            d.exl = q.exs[1];
        end
        // Tick source: divide by two, prescaler or pin
        if (baud | clkout)
        begin
            // Fixed two clocks per tick R10 R11
            if (q.pre >= DIV_BAUD - 4'h1)
            begin
                d.pre = 4'h0;
                tick = 1'b1;
            end
            else
            begin
                d.pre = q.pre + 4'h1;
            end
        end
        else if (q.ctl[B_CT])
        begin
            // Counter: count pin falling edges R15
            d.pre = 4'h0;
            tick = t2_edge;
        end
        else
        begin
            // Timer: prescaled clock by speed select R15
            if (q.pre >= (q.aux[B_SPD] ? DIV_FAST : DIV_SLOW)
                         - 4'h1)
            begin
                d.pre = 4'h0;
                tick = 1'b1;
            end
            else
            begin
                d.pre = q.pre + 4'h1;
            end
        end
        // Halted timer keeps its count R14
        if (!q.ctl[B_RUN])
        begin
            tick = 1'b0;
        end
        // Counter update
        if (tick)
        begin
            if (up)
            begin
                if (q.cnt == CNT_ALL1)
                begin
                    ovf = 1'b1; // R1
                    // Reload unless plain capture mode R12 R16
                    d.cnt = (baud | ~q.ctl[B_CPRL]) ? q.rcap
                                                     : CNT_RST;
                end
                else
                begin
                    d.cnt = q.cnt + 16'h0001;
                end
            end
            else if (q.cnt == q.rcap)
            begin
                // Underflow at reload value loads all ones R2 R22
                ovf = 1'b1;
                d.cnt = CNT_ALL1;
            end
            else
            begin
                d.cnt = q.cnt - 16'h0001;
            end
        end
        // Trigger: capture or reload outside baud mode
        if (trig & ~baud)
        begin
            if (q.ctl[B_CPRL])
            begin
                d.rcap = q.cnt; // R17
            end
            else
            begin
                d.cnt = q.rcap; // R16
            end
        end
        // Bus write data phase; bytes in the low lane
        if (q.wv)
        begin
            case (q.widx)
                IDX_CTL: d.ctl = hwdata[7:0];
                IDX_MODE: d.mode = hwdata[1:0];
                IDX_RLL: d.rcap[7:0] = hwdata[7:0];
                IDX_RLH: d.rcap[15:8] = hwdata[7:0];
                IDX_CNL: d.cnt[7:0] = hwdata[7:0];
                IDX_CNH: d.cnt[15:8] = hwdata[7:0];
                IDX_AUX: d.aux = hwdata[1:0];
                default: d.aux = d.aux; // Unmapped: ignored
            endcase
        end
        // Hardware flag sets win over a software clear
        if (ovf & ~baud)
        begin
            d.ctl[B_TF] = 1'b1; // R1 R2 R3 R4
        end
        if (ovf & dmode)
        begin
            d.ctl[B_EXF] = ~q.ctl[B_EXF]; // R6
        end
        else if (trig)
        begin
            d.ctl[B_EXF] = 1'b1; // R5
        end
        // Clock output toggles on every rollover R18
        d.ckoe = clkout;
        if (clkout & ovf)
        begin
            d.cko = ~q.cko;
        end
        // Baud ticks, serial modes 1 and 3 only R8 R9
        d.rxt = serial_mode[0] &
                (q.ctl[B_RXB] ? (ovf & baud) : other_timer_ovf);
        d.txt = serial_mode[0] &
                (q.ctl[B_TXB] ? (ovf & baud) : other_timer_ovf);
        // Masked OR of both flags, with suppressions R7 R21 R23
        d.irq = q.aux[B_IEN] &
                ((d.ctl[B_TF] & ~clkout) |
                 (d.ctl[B_EXF] & ~dmode));
        // Address phase: zero-wait slave, always ready
        d.rdy = 1'b1;
        d.wv = 1'b0;
        if (hsel & htrans[1] & hready)
        begin
            d.wv = hwrite;
            d.widx = haddr[9:2];
            d.rdata = hwrite ? 32'h0000_0000
                             : reg_read(haddr[9:2], q);
        end
        // Clock enable low freezes everything
        if (!clk_en)
        begin
            d = q;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------

    // Asynchronous reset to constants only
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            q <= '0;
            q.rdy <= 1'b1;
        end
        else
        begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // Outputs, all from flip-flops
    // ------------------------------------------------------------
    assign hreadyout = q.rdy;
    assign hresp = 1'b0 & q.rdy; // Always OKAY
    assign hrdata = q.rdata;
    assign count_input_pin_o = q.cko;
    assign count_input_pin_oe = q.ckoe;
    assign rx_baud_tick = q.rxt;
    assign tx_baud_tick = q.txt;
    assign timer_irq = q.irq;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_tf_on_wrap: assert property ( // R1
        (clk_en && tick && up && q.cnt == CNT_ALL1 && !baud)
        |=> q.ctl[B_TF])
        else $error("overflow flag missed on wrap");

    a_tf_down_eq: assert property ( // R2
        (clk_en && tick && dmode && !q.exl && q.cnt == q.rcap
         && !wr_cnt)
        |=> (q.ctl[B_TF] && q.cnt == CNT_ALL1))
        else $error("down underflow wrong");

    a_tf_no_baud: assert property ( // R3
        (clk_en && baud && !q.ctl[B_TF] && !wr_ctl)
        |=> !q.ctl[B_TF])
        else $error("overflow flag set in baud mode");

    a_tf_sticky: assert property ( // R4
        (q.ctl[B_TF] && !wr_ctl) |=> q.ctl[B_TF])
        else $error("overflow flag cleared by hardware");

    a_exf_edge: assert property ( // R5
        (clk_en && ex_edge && q.ctl[B_EXEN] && !q.ctl[B_CPRL]
         && !q.mode[B_DOWN_COUNT_ENABLE])
        |=> q.ctl[B_EXF])
        else $error("external flag not set on edge");

    a_run_hold: assert property ( // R14
        (clk_en && !q.ctl[B_RUN] && !wr_cnt && !trig)
        |=> $stable(q.cnt))
        else $error("count moved while halted");

    a_capture: assert property ( // R17
        (clk_en && trig && !baud && q.ctl[B_CPRL] && q.wv == 1'b0)
        |=> q.rcap == $past(q.cnt))
        else $error("capture value wrong");

    a_reload_ovf: assert property ( // R12
        (clk_en && tick && up && q.cnt == CNT_ALL1 && baud
         && !trig && !q.wv)
        |=> q.cnt == $past(q.rcap))
        else $error("baud reload missing");

    a_baud_rate: assert property ( // R11
        (clk_en && baud && q.ctl[B_RUN] && tick)
        |=> !tick)
        else $error("baud tick faster than two clocks");

    a_irq_mask: assert property ( // R21
        (clk_en && !q.aux[B_IEN]) |=> !timer_irq)
        else $error("interrupt passed while disabled");

    a_irq_dmode: assert property ( // R6
        (clk_en && dmode && !d.ctl[B_TF]) |=> !timer_irq)
        else $error("down-mode external flag raised irq");

    c_capture: cover property (trig && q.ctl[B_CPRL] && !baud);
    c_baud_wrap: cover property (ovf && baud);
    c_underflow: cover property (ovf && !up);
    c_clk_out: cover property (clkout && ovf);

endmodule // tcrc_top

/* tcrc_top_bench.sv */
// Self-checking bench for the timer 2 capture/reload counter.
// Speaks AHB-Lite to the registers and drives the pins directly.
// clk_en is driven by the bench; hready is looped back from hreadyout.
`timescale 1ns/10ps
module tcrc_top_bench import tcrc_pkg::*;;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic hclk, hresetn, hsel, hwrite, cnt_pin, trig, ovf_other, cen;
    logic [31:0] haddr, hwdata, v;
    logic [1:0] htrans, smode;
    logic [2:0] hsize;
    wire logic hreadyout, hresp, pin_o, pin_oe, rxt, txt, irq;
    wire logic [31:0] hrdata;
    int failures = 0; // Mismatch count
    int comparisons = 0; // Compare count
    int n;

    tcrc_top i_tcrc_top (.hclk(hclk), .hresetn(hresetn),
        .clk_en(cen), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .count_input_pin_i(cnt_pin),
        .count_input_pin_o(pin_o), .count_input_pin_oe(pin_oe),
        .trigger_pin(trig), .other_timer_ovf(ovf_other),
        .serial_mode(smode), .rx_baud_tick(rxt), .tx_baud_tick(txt),
        .timer_irq(irq));

    // Free-running 8 ns clock
    initial
    begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    // Compares one value and counts it
    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One single AHB-Lite transfer, entered just after a rising edge
    task automatic bus(input logic [7:0] idx, input logic we,
                       input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= {22'h000000, idx, 2'b00};
        htrans <= 2'b10;
        hwrite <= we;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] x;
        bus(idx, 1'b1, {24'h000000, d}, x);
    endtask

    // Reads a register and compares it with the expected byte
    task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
        logic [31:0] x;
        bus(idx, 1'b0, 32'h00000000, x);
        chk($sformatf("reg %h", idx), x, {24'h000000, exp});
    endtask

    // 16-bit count and reload writes, low byte first
    task automatic wcnt(input logic [15:0] d);
        wr(IDX_CNL, d[7:0]);
        wr(IDX_CNH, d[15:8]);
    endtask

    task automatic wrl(input logic [15:0] d);
        wr(IDX_RLL, d[7:0]);
        wr(IDX_RLH, d[15:8]);
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge hclk);
    endtask

    // Falling edge on the trigger pin, long enough for the sync
    task automatic fall();
        trig <= 1'b1;
        cyc(6);
        trig <= 1'b0;
        cyc(8);
    endtask

    // Cycles between two rising edges: 0 rx tick, 1 tx tick, 2 pin;
    // -1 when fewer than two rising edges come within 80 cycles
    task automatic gap(input int sel, output int g);
        logic p, c;
        int t0;
        g = -1;
        t0 = -1;
        p = 1'b1;
        for (int k = 0; k < 80 && g < 0; k++)
        begin
            @(posedge hclk);
            #1;
            c = (sel == 0) ? rxt : (sel == 1) ? txt : pin_o;
            if (c === 1'b1 && p === 1'b0)
            begin
                if (t0 >= 0)
                    g = k - t0;
                else
                    t0 = k;
            end
            p = c;
        end
        // Back onto a rising edge for the next stimulus
        @(posedge hclk);
    endtask

    // Ends the run with the counts and the verdict
    task automatic print_verdict();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Watchdog against a hung handshake
    // ------------------------------------------------------------
    initial
    begin
        repeat (20000) @(posedge hclk);
        failures++;
        print_verdict();
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial
    begin
        hresetn = 1'b0;
        hsel = 1'b0;
        hwrite = 1'b0;
        haddr = 32'h00000000;
        hwdata = 32'h00000000;
        htrans = 2'b00;
        hsize = 3'b010;
        cnt_pin = 1'b0;
        trig = 1'b0;
        ovf_other = 1'b0;
        smode = 2'b00;
        cen = 1'b1;
        cyc(6);
        hresetn <= 1'b1;
        cyc(1);
        // Reset values, unmapped place, reserved mode bits
        for (int i = 8'hC8; i <= 8'hCE; i++)
            rdc(i[7:0], 8'h00);
        wr(8'h10, 8'hFF);
        rdc(8'h10, 8'h00);
        wr(IDX_MODE, 8'hFF);
        rdc(IDX_MODE, 8'h03);
        wr(IDX_MODE, 8'h00);
        $display("test reset done");
        // Up-count roll, reload, sticky flag and interrupt mask
        wr(IDX_AUX, 8'h01);
        wrl(16'hFFF0);
        wcnt(16'hFFFE);
        wr(IDX_CTL, 8'h04);
        cyc(30);
        rdc(IDX_CNH, 8'hFF);
        rdc(IDX_CTL, 8'h84);
        chk("irq masked", irq, 1'b0);
        wr(IDX_AUX, 8'h03);
        cyc(2);
        chk("irq raised", irq, 1'b1);
        wr(IDX_CTL, 8'h04);
        rdc(IDX_CTL, 8'h04);
        cyc(70);
        rdc(IDX_CTL, 8'h84);
        wr(IDX_CTL, 8'h00);
        cyc(2);
        chk("irq cleared", irq, 1'b0);
        $display("test overflow done");
        // Halted count keeps its value
        wcnt(16'h1234);
        cyc(40);
        rdc(IDX_CNL, 8'h34);
        rdc(IDX_CNH, 8'h12);
        // Capture; first an edge with the trigger disabled
        wr(IDX_CTL, 8'h01);
        fall();
        rdc(IDX_CTL, 8'h01);
        wcnt(16'hABCD);
        wr(IDX_CTL, 8'h09);
        fall();
        rdc(IDX_RLL, 8'hCD);
        rdc(IDX_RLH, 8'hAB);
        rdc(IDX_CTL, 8'h49);
        chk("irq ext", irq, 1'b1);
        // Reload on trigger edge
        wrl(16'h5555);
        wcnt(16'h0000);
        wr(IDX_CTL, 8'h08);
        fall();
        rdc(IDX_CNL, 8'h55);
        rdc(IDX_CNH, 8'h55);
        rdc(IDX_CTL, 8'h48);
        wr(IDX_CTL, 8'h00);
        $display("test trigger done");
        // Down count: underflow at reload, flag toggles
        wr(IDX_MODE, 8'h01);
        wrl(16'h1000);
        wcnt(16'h1002);
        wr(IDX_CTL, 8'h04);
        cyc(24);
        rdc(IDX_CTL, 8'hC4);
        wr(IDX_CTL, 8'h00);
        rdc(IDX_CNH, 8'hFF);
        // Trigger high counts up
        wr(IDX_CTL, 8'h00);
        trig <= 1'b1;
        wcnt(16'h1000);
        wr(IDX_CTL, 8'h04);
        cyc(20);
        rdc(IDX_CTL, 8'h04);
        wr(IDX_CTL, 8'h00);
        rdc(IDX_CNH, 8'h10);
        wr(IDX_MODE, 8'h00);
        $display("test down count done");
        // Baud generator: own overflow every 4 ticks of 2 clocks
        wrl(16'hFFFC);
        wcnt(16'hFFFC);
        smode <= 2'b01;
        wr(IDX_CTL, 8'h24);
        gap(0, n);
        chk("rx period", n, 8);
        rdc(IDX_CTL, 8'h24);
        ovf_other <= 1'b1;
        cyc(1);
        ovf_other <= 1'b0;
        #1;
        chk("tx other pulse", txt, 1'b1);
        gap(1, n);
        chk("tx other", n, -1);
        wr(IDX_CTL, 8'h14);
        gap(1, n);
        chk("tx period", n, 8);
        smode <= 2'b00;
        gap(1, n);
        chk("tx mode 0", n, -1);
        wr(IDX_CTL, 8'h00);
        $display("test baud done");
        // Clock output: pin toggles per roll, no interrupt
        wr(IDX_MODE, 8'h02);
        wcnt(16'hFFFC);
        wr(IDX_CTL, 8'h04);
        gap(2, n);
        chk("clock out period", n, 16);
        chk("pin enable", pin_oe, 1'b1);
        chk("irq clock out", irq, 1'b0);
        wr(IDX_CTL, 8'h00);
        wr(IDX_MODE, 8'h00);
        cyc(2);
        chk("pin released", pin_oe, 1'b0);
        // Counter mode counts pin falls; slow timer every 12 clocks
        wcnt(16'h0000);
        cnt_pin <= 1'b1;
        wr(IDX_CTL, 8'h06);
        repeat (5)
        begin
            cyc(4);
            cnt_pin <= 1'b0;
            cyc(4);
            cnt_pin <= 1'b1;
        end
        cyc(8);
        wr(IDX_CTL, 8'h00);
        rdc(IDX_CNL, 8'h05);
        wr(IDX_AUX, 8'h00);
        wcnt(16'h0000);
        wr(IDX_CTL, 8'h04);
        cyc(118);
        wr(IDX_CTL, 8'h00);
        bus(IDX_CNL, 1'b0, 32'h00000000, v);
        chk("slow rate", v >= 9 && v <= 11, 1'b1);
        // Clock enable low freezes a running count
        wr(IDX_AUX, 8'h01);
        wcnt(16'h0000);
        wr(IDX_CTL, 8'h04);
        cen <= 1'b0;
        cyc(40);
        cen <= 1'b1;
        wr(IDX_CTL, 8'h00);
        bus(IDX_CNL, 1'b0, 32'h00000000, v);
        chk("frozen count", v <= 1, 1'b1);
        $display("test counter done");
        print_verdict();
    end
endmodule // tcrc_top_bench
